/* hw/tpi_defines.svh */
`ifndef TPI_DEFINES_SVH
`define TPI_DEFINES_SVH

`define TPI_NUM_CH 4
`define TPI_CHAR_W 10
`define TPI_BUF_DEPTH 2
`define TPI_RD_RESET 1'h0
`define TPI_PAIR_RESET 20'h00000
`define TPI_K28_IDX 5'h1c
`define TPI_K28_6B 6'h0f
`define TPI_D7_6B 6'h38
`define TPI_X3_4B 4'hc
`define TPI_A7_4B 4'h7
`define TPI_X7_IDX 3'h7

`endif

/* hw/tpi_pkg.sv */
`include "tpi_defines.svh"

package tpi_pkg;

  typedef struct packed {
    logic bit9;
    logic kreq;
    logic [7:0] data;
  } tpi_char_s;

  typedef struct packed {
    tpi_char_s first;
    tpi_char_s second;
  } tpi_pair_s;

  typedef struct packed {
    logic [`TPI_CHAR_W-1:0] first;
    logic [`TPI_CHAR_W-1:0] second;
  } tpi_sym_pair_s;

  typedef struct packed {
    logic [`TPI_NUM_CH-1:0] lane_valid;
    tpi_sym_pair_s [`TPI_NUM_CH-1:0] lane;
  } tpi_word_s;

  typedef struct packed {
    logic [`TPI_CHAR_W-1:0] sym;
    logic rd;
  } tpi_enc_s;

endpackage

/* hw/tpi_edge_capture.sv */
`timescale 1ns/1ps

module tpi_edge_capture #(
  parameter int W = 10
) (
  // link side
  input wire logic link_clk_in,
  input wire logic reset_n_in,
  input wire logic [W-1:0] data_in,
  // toward core
  output logic [2*W-1:0] pair_out,
  output logic toggle_out
);

  logic rst_meta_reg;
  logic rst_sync_n_reg;
  logic [W-1:0] rise_reg;
  logic [W-1:0] fall_reg;
  logic primed_reg;

  // release of reset is retimed to the link clock; assertion stays asynchronous
  always_ff @(posedge link_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_meta_reg <= 1'h0;
      rst_sync_n_reg <= 1'h0;
    end else begin
      rst_meta_reg <= 1'h1;
      rst_sync_n_reg <= rst_meta_reg;
    end
  end

  always_ff @(negedge link_clk_in or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      fall_reg <= '0;
    end else begin
      fall_reg <= data_in;
    end
  end

  always_ff @(posedge link_clk_in or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      rise_reg <= '0;
      primed_reg <= 1'h0;
    end else begin
      rise_reg <= data_in;
      primed_reg <= 1'h1;
    end
  end

  // the pair is complete one rising edge later; a stopped clock holds the last pair back
  always_ff @(posedge link_clk_in or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      pair_out <= '0;
      toggle_out <= 1'h0;
    end else if (primed_reg) begin
      pair_out <= {rise_reg, fall_reg};
      toggle_out <= ~toggle_out;
    end
  end

endmodule

/* hw/tpi_tx_port.sv */
`timescale 1ns/1ps
`include "tpi_defines.svh"

module tpi_tx_port
  import tpi_pkg::*;
(
  // core clock and chip reset
  input wire logic clock_in,
  input wire logic reset_n_in,
  // forwarded channel clocks
  input wire logic tx_clk_ch_a_in,
  input wire logic tx_clk_ch_b_in,
  input wire logic tx_clk_ch_c_in,
  input wire logic tx_clk_ch_d_in,
  // parallel transmit pins
  input wire logic [7:0] tx_data_ch_a_in,
  input wire logic tx_kreq_ch_a_in,
  input wire logic tx_bit9_ch_a_in,
  input wire logic [7:0] tx_data_ch_b_in,
  input wire logic tx_kreq_ch_b_in,
  input wire logic tx_bit9_ch_b_in,
  input wire logic [7:0] tx_data_ch_c_in,
  input wire logic tx_kreq_ch_c_in,
  input wire logic tx_bit9_ch_c_in,
  input wire logic [7:0] tx_data_ch_d_in,
  input wire logic tx_kreq_ch_d_in,
  input wire logic tx_bit9_ch_d_in,
  // mode straps
  input wire logic channel_lock_enable_in,
  input wire logic encoder_enable_in,
  // serializer path
  output logic ser_valid_out,
  input wire logic ser_ready_in,
  output tpi_word_s ser_word_out,
  // status
  output logic overrun_out
);

  localparam int NCH = `TPI_NUM_CH;
  localparam int CW = `TPI_CHAR_W;

  localparam logic [5:0] CODE6 [32] = '{
    6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
    6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
  localparam logic [3:0] CODE4 [8] = '{
    4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};

  // 8b/10b for one character; bit 0 of the result is the first bit on the line
  function automatic tpi_enc_s tpi_encode(input tpi_char_s c, input logic rd);
    logic [5:0] c6;
    logic [3:0] c4;
    logic rd6;
    logic k28;
    logic alt;
    logic [9:0] abcd;
    tpi_enc_s r;
    k28 = c.kreq && (c.data[4:0] == `TPI_K28_IDX);
    c6 = k28 ? `TPI_K28_6B : CODE6[c.data[4:0]];
    if (rd && (($countones(c6) != 3) || (c6 == `TPI_D7_6B))) begin
      c6 = ~c6;
    end
    rd6 = rd ^ ($countones(c6) != 3);
    alt = (c.data[7:5] == `TPI_X7_IDX) && (c.kreq ||
          (!rd6 && (c.data[4:0] inside {5'h11, 5'h12, 5'h14})) ||
          (rd6 && (c.data[4:0] inside {5'h0b, 5'h0d, 5'h0e})));
    c4 = alt ? `TPI_A7_4B : CODE4[c.data[7:5]];
    if (rd6 && (($countones(c4) != 2) || (c4 == `TPI_X3_4B))) begin
      c4 = ~c4;
    end
    if (k28 && !rd6 && (c.data[7:5] inside {3'h1, 3'h2, 3'h5, 3'h6})) begin
      c4 = ~c4;
    end
    abcd = {c6, c4};
    for (int i = 0; i < 10; i++) begin
      r.sym[i] = abcd[9-i];
    end
    r.rd = rd6 ^ ($countones(c4) != 2);
    return r;
  endfunction

  // capture: channel A clock takes all four channels, the other clocks their own
  tpi_char_s [NCH-1:0] pin_char;
  logic [4*CW*2-1:0] a_pair;
  logic [CW*2-1:0] own_pair [1:NCH-1];
  logic [NCH-1:0] src_toggle;
  logic [NCH-1:0] tog_s1_reg;
  logic [NCH-1:0] tog_s2_reg;
  logic [NCH-1:0] tog_s3_reg;
  logic [NCH-1:0] src_event;
  logic lock_s1_reg;
  logic lock_s2_reg;
  logic enc_s1_reg;
  logic enc_s2_reg;

  assign pin_char[0] = '{bit9: tx_bit9_ch_a_in, kreq: tx_kreq_ch_a_in, data: tx_data_ch_a_in};
  assign pin_char[1] = '{bit9: tx_bit9_ch_b_in, kreq: tx_kreq_ch_b_in, data: tx_data_ch_b_in};
  assign pin_char[2] = '{bit9: tx_bit9_ch_c_in, kreq: tx_kreq_ch_c_in, data: tx_data_ch_c_in};
  assign pin_char[3] = '{bit9: tx_bit9_ch_d_in, kreq: tx_kreq_ch_d_in, data: tx_data_ch_d_in};

  tpi_edge_capture #(.W(4*CW)) u_cap_a (
    .link_clk_in(tx_clk_ch_a_in),
    .reset_n_in(reset_n_in),
    .data_in(pin_char),
    .pair_out(a_pair),
    .toggle_out(src_toggle[0])
  );

  tpi_edge_capture #(.W(CW)) u_cap_b (
    .link_clk_in(tx_clk_ch_b_in),
    .reset_n_in(reset_n_in),
    .data_in(pin_char[1]),
    .pair_out(own_pair[1]),
    .toggle_out(src_toggle[1])
  );

  tpi_edge_capture #(.W(CW)) u_cap_c (
    .link_clk_in(tx_clk_ch_c_in),
    .reset_n_in(reset_n_in),
    .data_in(pin_char[2]),
    .pair_out(own_pair[2]),
    .toggle_out(src_toggle[2])
  );

  tpi_edge_capture #(.W(CW)) u_cap_d (
    .link_clk_in(tx_clk_ch_d_in),
    .reset_n_in(reset_n_in),
    .data_in(pin_char[3]),
    .pair_out(own_pair[3]),
    .toggle_out(src_toggle[3])
  );

  // pair data stays put for a whole link period, far longer than the toggle's sync delay
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tog_s1_reg <= '0;
      tog_s2_reg <= '0;
      tog_s3_reg <= '0;
    end else begin
      tog_s1_reg <= src_toggle;
      tog_s2_reg <= tog_s1_reg;
      tog_s3_reg <= tog_s2_reg;
    end
  end

  assign src_event = tog_s2_reg ^ tog_s3_reg;

  // mode straps; changing them mid-stream corrupts the words in flight
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      lock_s1_reg <= 1'h0;
      lock_s2_reg <= 1'h0;
      enc_s1_reg <= 1'h0;
      enc_s2_reg <= 1'h0;
    end else begin
      lock_s1_reg <= channel_lock_enable_in;
      lock_s2_reg <= lock_s1_reg;
      enc_s1_reg <= encoder_enable_in;
      enc_s2_reg <= enc_s1_reg;
    end
  end

  // per-channel source select
  logic [NCH-1:0] ch_new;
  tpi_pair_s [NCH-1:0] ch_pair;

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      ch_pair[i].first = a_pair[CW*NCH+CW*i +: CW];
      ch_pair[i].second = a_pair[CW*i +: CW];
      ch_new[i] = src_event[0];
    end
    // channel A has no own capture apart from the shared one, so the loop starts at B
    for (int i = 1; i < NCH; i++) begin
      if (!lock_s2_reg) begin
        ch_pair[i] = own_pair[i];
        ch_new[i] = src_event[i];
      end
    end
  end

  // one pending pair per channel in front of the buffer
  logic [NCH-1:0] pend_reg;
  tpi_pair_s [NCH-1:0] pend_data_reg;
  logic [NCH-1:0] rd_reg;
  logic overrun_reg;
  logic push;
  logic buf_in_ready;
  tpi_word_s push_word;
  logic [NCH-1:0] rd_next;

  assign push = (|pend_reg) && buf_in_ready;

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pend_reg <= '0;
      pend_data_reg <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (ch_new[i]) begin
          pend_reg[i] <= 1'h1;
          pend_data_reg[i] <= ch_pair[i];
        end else if (push) begin
          pend_reg[i] <= 1'h0;
        end
      end
    end
  end

  // a second pair before the first left means the serializer stalled too long
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      overrun_reg <= 1'h0;
    end else if (|(ch_new & pend_reg) && !push) begin
      overrun_reg <= 1'h1;
    end
  end

  assign overrun_out = overrun_reg;

  always_comb begin
    tpi_enc_s e1;
    tpi_enc_s e2;
    e1 = '0;
    e2 = '0;
    push_word = '0;
    rd_next = rd_reg;
    push_word.lane_valid = pend_reg;
    for (int i = 0; i < NCH; i++) begin
      if (enc_s2_reg) begin
        e1 = tpi_encode(pend_data_reg[i].first, rd_reg[i]);
        e2 = tpi_encode(pend_data_reg[i].second, e1.rd);
        push_word.lane[i].first = e1.sym;
        push_word.lane[i].second = e2.sym;
        if (pend_reg[i]) begin
          rd_next[i] = e2.rd;
        end
      end else begin
        push_word.lane[i].first = pend_data_reg[i].first;
        push_word.lane[i].second = pend_data_reg[i].second;
      end
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rd_reg <= {NCH{`TPI_RD_RESET}};
    end else if (push) begin
      rd_reg <= rd_next;
    end
  end

  // two-entry buffer toward the serializer
  localparam int DEPTH = `TPI_BUF_DEPTH;
  tpi_word_s buf_mem [DEPTH];
  logic buf_wr_ptr_reg;
  logic buf_rd_ptr_reg;
  logic [1:0] buf_count_reg;
  logic buf_pop;

  assign buf_in_ready = (buf_count_reg != 2'(DEPTH));
  assign ser_valid_out = (buf_count_reg != 2'h0);
  assign buf_pop = ser_valid_out && ser_ready_in;
  assign ser_word_out = buf_mem[buf_rd_ptr_reg];

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      buf_mem[0] <= '0;
      buf_mem[1] <= '0;
    end else if (push) begin
      buf_mem[buf_wr_ptr_reg] <= push_word;
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      buf_wr_ptr_reg <= 1'h0;
      buf_rd_ptr_reg <= 1'h0;
      buf_count_reg <= 2'h0;
    end else begin
      if (push) begin
        buf_wr_ptr_reg <= ~buf_wr_ptr_reg;
      end
      if (buf_pop) begin
        buf_rd_ptr_reg <= ~buf_rd_ptr_reg;
      end
      buf_count_reg <= 2'(buf_count_reg + 2'(push) - 2'(buf_pop));
    end
  end

endmodule

/* test/tpi_tx_port_asserts.sv */
`timescale 1ns/1ps
module tpi_tx_port_chk
  import tpi_pkg::*;
(
  // core side
  input wire logic clock_in,
  input wire logic reset_n_in,
  // straps
  input wire logic channel_lock_enable_in,
  input wire logic encoder_enable_in,
  // serializer path
  input wire logic ser_valid_out,
  input wire logic ser_ready_in,
  input wire tpi_word_s ser_word_out,
  input wire logic overrun_out
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!reset_n_in);

  // each coded symbol holds 4..6 ones and a chained pair 9..11
  function automatic logic enc_ok(tpi_word_s w);
    int a;
    int b;
    enc_ok = 1'b1;
    for (int i = 0; i < 4; i++) begin
      a = $countones(w.lane[i].first);
      b = $countones(w.lane[i].second);
      if (w.lane_valid[i] && (a < 4 || a > 6 || b < 4 || b > 6 || a + b < 9 || a + b > 11))
        enc_ok = 1'b0;
    end
  endfunction

  sequence stalled;
    ser_valid_out && !ser_ready_in;
  endsequence
  // straps pass a two-flop sync, so give them time to settle
  sequence lock_held;
    channel_lock_enable_in [*6];
  endsequence
  sequence enc_held;
    encoder_enable_in [*6];
  endsequence

  AST_RESET_CLEAN: assert property ($rose(reset_n_in) |-> !ser_valid_out && !overrun_out)
    else $error("outputs not clear after reset");
  AST_STALL_HOLD: assert property (stalled |=> ser_valid_out && $stable(ser_word_out))
    else $error("word changed while stalled");
  AST_OVERRUN_STICKY: assert property (overrun_out |=> overrun_out)
    else $error("overrun flag dropped");
  AST_OVERRUN_CAUSE: assert property ($rose(overrun_out) |-> $past(!ser_ready_in)
    || $past(!ser_ready_in, 2) || $past(!ser_ready_in, 3))
    else $error("overrun without a stall");
  AST_LOCK_FULL: assert property (lock_held ##0 ser_valid_out |->
    ser_word_out.lane_valid == 4'hf)
    else $error("locked word missing lanes");
  AST_LANE_PRESENT: assert property (ser_valid_out |-> ser_word_out.lane_valid != 4'h0)
    else $error("valid word with no lane");
  AST_ENC_SYMBOLS: assert property (enc_held ##0 ser_valid_out |-> enc_ok(ser_word_out))
    else $error("coded symbol out of balance");
  AST_VALID_DROP: assert property ($fell(ser_valid_out) |-> $past(ser_ready_in))
    else $error("valid dropped without a take");
endmodule

bind tpi_tx_port tpi_tx_port_chk u_chk (
  .clock_in(clock_in),
  .reset_n_in(reset_n_in),
  .channel_lock_enable_in(channel_lock_enable_in),
  .encoder_enable_in(encoder_enable_in),
  .ser_valid_out(ser_valid_out),
  .ser_ready_in(ser_ready_in),
  .ser_word_out(ser_word_out),
  .overrun_out(overrun_out)
);

/* test/tpi_tx_partner.sv */
`timescale 1ns/1ps
module tpi_tx_partner
  import tpi_pkg::*;
(
  // control
  input wire logic run_in,
  input wire logic lock_in,
  input wire logic enc_in,
  // parallel link
  output logic [3:0] clk_out,
  output tpi_char_s [3:0] chr_out
);
  logic [3:0] clk_int = 4'h0;
  // locked: only the channel a clock is supplied, the rest stand still
  assign clk_out = lock_in ? {3'h0, clk_int[0]} : clk_int;
  for (genvar c = 0; c < 4; c++) begin : g_ch
    logic [5:0] n = 6'h00;
    initial begin
      chr_out[c] = '0;
      forever begin
        if (!run_in) begin
          // released lines must not look like the last char
          chr_out[c] = ~chr_out[c];
          wait (run_in);
          #(lock_in ? 0 : 7 * c);
        end
        // coded mode: a and c ask for a K-char, bit 9 high to show it is ignored
        chr_out[c] = enc_in ? {1'b1, c % 2 == 0, 8'hbc} : {2'h2, 2'(c), n};
        #12 clk_int[c] = 1'b1;
        #12 chr_out[c] = enc_in ? {1'b1, c % 2 == 0, 8'hbc} : {2'h1, 2'(c), n};
        #12 clk_int[c] = 1'b0;
        #12 n = n + 6'h01;
      end
    end
  end
endmodule

/* test/tpi_tx_port_tb_top.sv */
`timescale 1ns/1ps
module tpi_tx_port_tb_top;
  import tpi_pkg::*;
  logic clock_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic lock = 1'b1;
  logic enc = 1'b0;
  logic run = 1'b0;
  logic ready = 1'b1;
  logic seq_on = 1'b1;
  logic ser_valid;
  logic overrun;
  logic [3:0] lclk;
  logic [3:0] seen = 4'h0;
  logic [5:0] last_n [4];
  tpi_char_s [3:0] chr;
  tpi_word_s word;
  int n_fail = 0;
  int total_checks = 0;
  int words = 0;

  always #2.5 clock_in = ~clock_in;

  tpi_tx_partner u_far (.run_in(run), .lock_in(lock), .enc_in(enc), .clk_out(lclk),
    .chr_out(chr));

  tpi_tx_port uut (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .tx_clk_ch_a_in(lclk[0]),
    .tx_clk_ch_b_in(lclk[1]),
    .tx_clk_ch_c_in(lclk[2]),
    .tx_clk_ch_d_in(lclk[3]),
    .tx_data_ch_a_in(chr[0].data),
    .tx_kreq_ch_a_in(chr[0].kreq),
    .tx_bit9_ch_a_in(chr[0].bit9),
    .tx_data_ch_b_in(chr[1].data),
    .tx_kreq_ch_b_in(chr[1].kreq),
    .tx_bit9_ch_b_in(chr[1].bit9),
    .tx_data_ch_c_in(chr[2].data),
    .tx_kreq_ch_c_in(chr[2].kreq),
    .tx_bit9_ch_c_in(chr[2].bit9),
    .tx_data_ch_d_in(chr[3].data),
    .tx_kreq_ch_d_in(chr[3].kreq),
    .tx_bit9_ch_d_in(chr[3].bit9),
    .channel_lock_enable_in(lock),
    .encoder_enable_in(enc),
    .ser_valid_out(ser_valid),
    .ser_ready_in(ready),
    .ser_word_out(word),
    .overrun_out(overrun)
  );

  task automatic check(input string what, input logic [19:0] got, input logic [19:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic bound(input int i, input int lim);
    if (i >= lim) begin
      check("wait bound", 20'h0, 20'h1);
      end_sim();
    end
  endtask

  task automatic mon_lane(input int c, input tpi_sym_pair_s p);
    logic [5:0] n;
    n = p.first[5:0];
    if (enc) begin
      check("coded pair", p, c % 2 == 0 ? 20'h5f283 : 20'h5715c);
    end else begin
      check("raw pair", p, {2'h2, 2'(c), n, 2'h1, 2'(c), n});
      if (seq_on && seen[c])
        check("order", 20'(n), 20'(6'(last_n[c] + 6'h01)));
      seen[c] = 1'b1;
      last_n[c] = n;
    end
  endtask

  always @(posedge clock_in) begin
    if (reset_n_in && ser_valid && ready) begin
      words++;
      if (lock)
        check("lane mask", 20'(word.lane_valid), 20'hf);
      for (int c = 0; c < 4; c++) begin
        if (word.lane_valid[c])
          mon_lane(c, word.lane[c]);
      end
    end
  end

  task automatic do_reset(input logic lk, input logic en);
    run = 1'b0;
    @(posedge clock_in) #1;
    reset_n_in = 1'b0;
    lock = lk;
    enc = en;
    seen = 4'h0;
    repeat (20) @(posedge clock_in);
    check("reset outs", {18'h0, ser_valid, overrun}, 20'h0);
    check("reset word", 20'(word !== '0), 20'h0);
    #1 reset_n_in = 1'b1;
    run = 1'b1;
  endtask

  // one of the four strap settings, traffic on all channels
  task automatic sc_stream(input logic lk, input logic en);
    int w0;
    do_reset(lk, en);
    w0 = words;
    repeat (1000) @(posedge clock_in);
    check("word count", 20'(words - w0 > 60), 20'h1);
    check("no overrun", 20'(overrun), 20'h0);
  endtask

  // fill until the overrun flag sets, then drain until empty with the link stopped
  task automatic sc_stall;
    int i;
    do_reset(1'b1, 1'b0);
    seq_on = 1'b0;
    @(posedge clock_in) #1 ready = 1'b0;
    for (i = 0; overrun !== 1'b1 && i < 2000; i++) begin
      @(posedge clock_in);
      #1;
    end
    bound(i, 2000);
    check("held valid", 20'(ser_valid), 20'h1);
    run = 1'b0;
    repeat (40) @(posedge clock_in);
    #1 ready = 1'b1;
    for (i = 0; ser_valid !== 1'b0 && i < 200; i++) begin
      @(posedge clock_in);
      #1;
    end
    bound(i, 200);
    check("sticky", 20'(overrun), 20'h1);
    do_reset(1'b1, 1'b0);
    seq_on = 1'b1;
    repeat (200) @(posedge clock_in);
  endtask

  initial begin
    sc_stream(1'b1, 1'b0);
    sc_stream(1'b0, 1'b0);
    sc_stream(1'b1, 1'b1);
    sc_stream(1'b0, 1'b1);
    sc_stall();
    end_sim();
  end

  initial begin
    #100000;
    bound(1, 0);
  end
endmodule
